// ==== msd_pkg.sv ====
package msd_pkg;

  // ****************************************
  // Address map (24-bit physical)
  // ****************************************
  localparam logic [23:0] SFR_BASE = 24'h00FE00;
  localparam logic [23:0] SFR_END = 24'h00FFFF;
  localparam logic [23:0] EXTENDED_REGISTER_BLOCK_BASE = 24'h00F000;
  localparam logic [23:0] EXTENDED_REGISTER_BLOCK_END = 24'h00F1FF;
  localparam logic [23:0] IRAM_BASE = 24'h00FA00;
  localparam logic [23:0] IRAM_END = 24'h00FDFF;
  localparam logic [23:0] IRAM_BIT_BASE = 24'h00FD00;
  localparam logic [23:0] EXTENSION_RAM_BASE = 24'h00E000;
  localparam logic [23:0] EXTENSION_RAM_END = 24'h00E7FF;
  localparam logic [23:0] BLK_BIT_HALF = 24'h000100;
  localparam logic [3:0] GPR_SHORT_TAG = 4'hF;

  // ****************************************
  // Register port indices and fields
  // ****************************************
  localparam logic [2:0] RG_SYSCFG = 3'h0;
  localparam logic [2:0] RG_DPP0 = 3'h1;
  localparam logic [2:0] RG_DPP3 = 3'h4;
  localparam logic [2:0] RG_CSP = 3'h5;
  localparam logic [2:0] RG_CP = 3'h6;
  localparam logic [2:0] RG_STATUS = 3'h7;
  localparam int SYSCFG_XEN_BIT = 0;
  localparam int SYSCFG_SHARE_BIT = 1;
  localparam logic [1:0] SYSCFG_RESET = 2'h0;
  localparam logic [9:0] DPP_RESET = 10'h000;
  localparam logic [15:0] CP_RESET = 16'hFC00;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int PHASE_UNIT_NS = CLK_PERIOD_NS / 2;
  localparam int EXTENSION_RAM_PHASE_UNITS = 4;
  localparam int EXTENSION_RAM_CYC_INT = (EXTENSION_RAM_PHASE_UNITS * PHASE_UNIT_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
  localparam logic [1:0] EXTENSION_RAM_CYC = 2'(EXTENSION_RAM_CYC_INT);

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {RGN_EXT, RGN_SFR, RGN_EXTENDED_REGISTER_BLOCK, RGN_IRAM, RGN_EXTENSION_RAM} msd_region_t;
  typedef enum logic [1:0] {AM_LONG, AM_SHORT, AM_BIT, AM_GPR} msd_amode_t;
  typedef enum logic [1:0] {BO_NONE, BO_TEST, BO_SET, BO_CLR} msd_bitop_t;
  typedef enum logic [1:0] {BK_64K, BK_256K, BK_1M, BK_8M} msd_bank_t;
  typedef enum logic [1:0] {BUS_MUX16, BUS_MUX8, BUS_DMX16, BUS_DMX8} msd_bus_t;

endpackage

// ==== msd_word_ram.sv ====
`timescale 1ns/1ps
module msd_word_ram #(
  parameter int DEPTH = 1024,
  parameter int AW = 10
) (
  // Clock
  input wire logic ref_clk,
  input wire logic ce,
  // Access
  input wire logic en,
  input wire logic we,
  input wire logic [1:0] be,
  input wire logic [AW-1:0] addr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata_q
);

  logic [15:0] mem [DEPTH];

  // No reset on the array; read data comes from a register
  genvar g;
  for (g = 0; g < 2; g++) begin : g_lane
    always_ff @(posedge ref_clk) begin
      if (ce && en) begin
        if (we && be[g]) begin
          mem[addr][8*g +: 8] <= wdata[8*g +: 8];
        end
        rdata_q[8*g +: 8] <= mem[addr][8*g +: 8];
      end
    end
  end

endmodule

// ==== msd_addr_map.sv ====
`timescale 1ns/1ps
module msd_addr_map
  import msd_pkg::*;
(
  // Physical address in
  input wire logic [23:0] phys,
  input wire logic extension_ram_en,
  // Classification out
  output msd_region_t region,
  output logic upper_half,
  output logic [8:0] blk_idx
);

  // ****************************************
  // On-chip regions are checked before the external fallback
  // ****************************************
  always_comb begin
    region = RGN_EXT;
    upper_half = 1'b0;
    blk_idx = 9'h000;
    if (phys >= SFR_BASE && phys <= SFR_END) begin
      region = RGN_SFR;
      upper_half = phys[8];
      blk_idx = {1'b0, phys[8:1]};
    end else if (phys >= EXTENDED_REGISTER_BLOCK_BASE && phys <= EXTENDED_REGISTER_BLOCK_END) begin
      region = RGN_EXTENDED_REGISTER_BLOCK;
      upper_half = phys[8];
      blk_idx = {1'b1, phys[8:1]};
    end else if (phys >= IRAM_BASE && phys <= IRAM_END) begin
      region = RGN_IRAM;
    end else if (extension_ram_en && phys >= EXTENSION_RAM_BASE && phys <= EXTENSION_RAM_END) begin
      region = RGN_EXTENSION_RAM;
    end
  end

endmodule

// ==== msd_decoder.sv ====
`timescale 1ns/1ps
module msd_decoder
  import msd_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [15:0] reg_rdata,
  // CPU access
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic cpu_byte,
  input wire logic cpu_fetch,
  input wire logic cpu_seq,
  input wire msd_amode_t cpu_mode,
  input wire msd_bitop_t cpu_bitop,
  input wire logic [3:0] cpu_bitpos,
  input wire logic [15:0] cpu_addr,
  input wire logic [15:0] cpu_wdata,
  output logic [15:0] cpu_rdata,
  output logic cpu_done,
  output logic cpu_err,
  output logic cpu_bit,
  output msd_region_t region,
  // Instruction events
  input wire logic extended_window_switch,
  input wire logic [1:0] extended_window_switch_count_m1,
  input wire logic instr_retire,
  input wire logic end_of_init_instruction,
  input wire logic segment_branch,
  input wire logic [7:0] seg_target,
  // Reset straps
  input wire logic external_access_pin_n,
  input wire logic [3:0] port0_strap,
  output msd_bus_t bus_mode,
  output msd_bank_t bank_mode,
  // Far side: external bus and internal RAM
  output logic ext_req,
  output logic iram_req,
  output logic far_we,
  output logic far_byte,
  output logic [15:0] far_addr,
  output logic [6:0] port4_addr,
  output logic [15:0] far_wdata,
  input wire logic far_ack,
  input wire logic [15:0] far_rdata,
  // External master
  input wire logic xm_hold,
  input wire logic xm_req,
  input wire logic xm_we,
  input wire logic [1:0] xm_be,
  input wire logic [23:0] xm_addr,
  input wire logic [15:0] xm_wdata,
  output logic [15:0] xm_rdata,
  output logic xm_ack,
  output logic xm_err
);

  typedef enum logic [2:0] {ST_IDLE, ST_SFR_RD, ST_EXTENSION_RAM, ST_FAR} msd_state_t;

  localparam int XR_DLY = 2;

  msd_state_t st_q;
  logic [1:0] syscfg_q;
  logic [9:0] dpp_q [4];
  logic [7:0] csp_q;
  logic [15:0] cp_q;
  logic locked_q, strap_done_q, ext_access_q;
  logic [2:0] extended_window_switch_left_q;
  logic [1:0] cnt_q;
  logic hold_xm_q, hold_lsb_q, hold_byte_q;
  msd_bitop_t hold_bitop_q;
  logic [3:0] hold_pos_q;
  logic [8:0] hold_idx_q;
  msd_region_t last_fetch_q;
  logic ext_window;
  logic [23:0] win_base, phys_d, sel_phys;
  msd_region_t rg;
  logic upper, take, xm_take, xm_ok, acc_err;
  logic [8:0] blk_idx;
  logic sr_en, sr_we;
  logic [8:0] sr_addr;
  logic [15:0] sr_wdata, sr_rdata, bit_mask;
  logic xr_en, xr_we;
  logic [1:0] xr_be;
  logic [9:0] xr_addr;
  logic [15:0] xr_wdata, xr_rdata;

  // ****************************************
  // Address formation
  // ****************************************
  assign ext_window = (extended_window_switch_left_q != 3'h0);
  assign win_base = ext_window ? EXTENDED_REGISTER_BLOCK_BASE : SFR_BASE;

  always_comb begin
    phys_d = 24'h000000;
    case (cpu_mode)
      AM_LONG: phys_d = {dpp_q[cpu_addr[15:14]], cpu_addr[13:0]};
      AM_SHORT: begin
        if (cpu_addr[7:4] == GPR_SHORT_TAG) begin
          phys_d = {8'h00, cp_q + {11'h000, cpu_addr[3:0], 1'b0}};
        end else begin
          // Only even addresses: high bytes are not reachable here
          phys_d = win_base + {15'h0000, cpu_addr[7:0], 1'b0};
        end
      end
      AM_BIT: begin
        if (cpu_addr[7:4] == GPR_SHORT_TAG) begin
          phys_d = {8'h00, cp_q + {11'h000, cpu_addr[3:0], 1'b0}};
        end else if (!cpu_addr[7]) begin
          phys_d = win_base + BLK_BIT_HALF + {16'h0000, cpu_addr[6:0], 1'b0};
        end else begin
          phys_d = IRAM_BIT_BASE + {16'h0000, cpu_addr[6:0], 1'b0};
        end
      end
      AM_GPR: phys_d = {8'h00, cp_q + {11'h000, cpu_addr[3:0], 1'b0}};
      default: phys_d = 24'h000000;
    endcase
  end

  // The code segment is fixed for a fetch; no carry into it
  assign sel_phys = cpu_fetch ? {csp_q, cpu_addr} : phys_d;

  msd_addr_map u_map (
    .phys(sel_phys),
    .extension_ram_en(syscfg_q[SYSCFG_XEN_BIT]),
    .region(rg),
    .upper_half(upper),
    .blk_idx(blk_idx)
  );

  // ****************************************
  // Access checks
  // ****************************************
  assign take = (st_q == ST_IDLE) && cpu_req && !xm_hold;
  assign xm_take = (st_q == ST_IDLE) && xm_hold && xm_req;
  assign xm_ok = syscfg_q[SYSCFG_SHARE_BIT] && syscfg_q[SYSCFG_XEN_BIT]
                 && xm_addr >= EXTENSION_RAM_BASE && xm_addr <= EXTENSION_RAM_END && !xm_addr[0];

  always_comb begin
    acc_err = 1'b0;
    if ((!cpu_byte || cpu_fetch) && sel_phys[0]) begin
      acc_err = 1'b1;
    end
    if (cpu_bitop != BO_NONE && !((rg == RGN_SFR || rg == RGN_EXTENDED_REGISTER_BLOCK) && upper)) begin
      acc_err = 1'b1;
    end
    if (cpu_fetch && cpu_seq && rg != last_fetch_q) begin
      acc_err = 1'b1;
    end
  end

  // ****************************************
  // Register block storage
  // ****************************************
  assign bit_mask = 16'h0001 << hold_pos_q;

  always_comb begin
    sr_en = 1'b0;
    sr_we = 1'b0;
    sr_addr = blk_idx;
    sr_wdata = cpu_wdata;
    if (st_q == ST_SFR_RD) begin
      sr_addr = hold_idx_q;
      sr_en = (hold_bitop_q == BO_SET) || (hold_bitop_q == BO_CLR);
      sr_we = sr_en;
      sr_wdata = (hold_bitop_q == BO_SET) ? (sr_rdata | bit_mask) : (sr_rdata & ~bit_mask);
    end else if (take && !acc_err && (rg == RGN_SFR || rg == RGN_EXTENDED_REGISTER_BLOCK)) begin
      sr_en = 1'b1;
      sr_we = cpu_we && (cpu_bitop == BO_NONE);
      if (cpu_byte) begin
        // Whole word written so the other byte becomes zero
        sr_wdata = sel_phys[0] ? {cpu_wdata[7:0], 8'h00} : {8'h00, cpu_wdata[7:0]};
      end
    end
  end

  msd_word_ram #(.DEPTH(512), .AW(9)) u_sfr_mem (
    .ref_clk(ref_clk),
    .ce(ce),
    .en(sr_en),
    .we(sr_we),
    .be(2'b11),
    .addr(sr_addr),
    .wdata(sr_wdata),
    .rdata_q(sr_rdata)
  );

  // ****************************************
  // Extension RAM, shared with a held external master
  // ****************************************
  always_comb begin
    xr_en = 1'b0;
    xr_we = 1'b0;
    xr_be = 2'b11;
    xr_addr = sel_phys[10:1];
    xr_wdata = cpu_byte ? {cpu_wdata[7:0], cpu_wdata[7:0]} : cpu_wdata;
    if (xm_take) begin
      xr_en = xm_ok;
      xr_we = xm_we;
      xr_be = xm_be;
      xr_addr = xm_addr[10:1];
      xr_wdata = xm_wdata;
    end else if (take && !acc_err && rg == RGN_EXTENSION_RAM) begin
      xr_en = 1'b1;
      xr_we = cpu_we;
      if (cpu_byte) begin
        xr_be = sel_phys[0] ? 2'b10 : 2'b01;
      end
    end
  end

  msd_word_ram #(.DEPTH(1024), .AW(10)) u_extension_ram (
    .ref_clk(ref_clk),
    .ce(ce),
    .en(xr_en),
    .we(xr_we),
    .be(xr_be),
    .addr(xr_addr),
    .wdata(xr_wdata),
    .rdata_q(xr_rdata)
  );

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      syscfg_q <= SYSCFG_RESET;
      locked_q <= 1'b0;
      cp_q <= CP_RESET;
      for (int i = 0; i < 4; i++) begin
        dpp_q[i] <= DPP_RESET;
      end
    end else if (ce) begin
      if (end_of_init_instruction) begin
        locked_q <= 1'b1;
      end
      if (reg_we && reg_addr == RG_SYSCFG && !locked_q) begin
        syscfg_q <= reg_wdata[1:0];
      end
      if (reg_we && reg_addr >= RG_DPP0 && reg_addr <= RG_DPP3) begin
        dpp_q[2'(reg_addr - RG_DPP0)] <= reg_wdata[9:0];
      end
      // A register bank may not sit in the extension RAM range
      if (reg_we && reg_addr == RG_CP
          && !({8'h00, reg_wdata} >= EXTENSION_RAM_BASE && {8'h00, reg_wdata} <= EXTENSION_RAM_END)) begin
        cp_q <= reg_wdata;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else if (ce) begin
      reg_rdata <= 16'h0000;
      if (reg_re) begin
        case (reg_addr)
          RG_SYSCFG: reg_rdata <= {14'h0000, syscfg_q};
          RG_CSP: reg_rdata <= {8'h00, csp_q};
          RG_CP: reg_rdata <= cp_q;
          RG_STATUS: reg_rdata <= {5'h00, region, bank_mode, bus_mode,
                                   ext_access_q, ext_window, locked_q};
          default: reg_rdata <= {6'h00, dpp_q[2'(reg_addr - RG_DPP0)]};
        endcase
      end
    end
  end

  // ****************************************
  // Code segment and window scope
  // ****************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      csp_q <= 8'h00;
    end else if (ce && segment_branch) begin
      csp_q <= seg_target;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      extended_window_switch_left_q <= 3'h0;
    end else if (ce) begin
      if (extended_window_switch) begin
        extended_window_switch_left_q <= {1'b0, extended_window_switch_count_m1} + 3'h1;
      end else if (instr_retire && ext_window) begin
        extended_window_switch_left_q <= extended_window_switch_left_q - 3'h1;
      end
    end
  end

  // ****************************************
  // Straps caught on the first enabled edge after release
  // ****************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      strap_done_q <= 1'b0;
      bus_mode <= BUS_MUX16;
      bank_mode <= BK_64K;
      ext_access_q <= 1'b0;
    end else if (ce && !strap_done_q) begin
      strap_done_q <= 1'b1;
      bus_mode <= msd_bus_t'(port0_strap[1:0]);
      bank_mode <= msd_bank_t'(port0_strap[3:2]);
      ext_access_q <= !external_access_pin_n;
    end
  end

  // ****************************************
  // Access sequencer
  // ****************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= ST_IDLE;
      cnt_q <= 2'h0;
      {hold_xm_q, hold_lsb_q, hold_byte_q} <= 3'h0;
      hold_bitop_q <= BO_NONE;
      hold_pos_q <= 4'h0;
      hold_idx_q <= 9'h000;
      last_fetch_q <= RGN_EXT;
      region <= RGN_EXT;
      {cpu_done, cpu_err, cpu_bit, xm_ack, xm_err, ext_req, iram_req} <= 7'h00;
      {far_we, far_byte} <= 2'h0;
      cpu_rdata <= 16'h0000;
      xm_rdata <= 16'h0000;
      far_addr <= 16'h0000;
      far_wdata <= 16'h0000;
      port4_addr <= 7'h00;
    end else if (ce) begin
      {cpu_done, cpu_err, xm_ack, xm_err, ext_req, iram_req} <= 6'h00;
      case (st_q)
        ST_IDLE: begin
          if (xm_take) begin
            if (xm_ok) begin
              st_q <= ST_EXTENSION_RAM;
              cnt_q <= EXTENSION_RAM_CYC - 2'h1;
              hold_xm_q <= 1'b1;
            end else begin
              xm_err <= 1'b1;
            end
          end else if (take) begin
            region <= rg;
            hold_lsb_q <= sel_phys[0];
            hold_byte_q <= cpu_byte;
            hold_bitop_q <= cpu_bitop;
            hold_pos_q <= cpu_bitpos;
            hold_idx_q <= blk_idx;
            if (cpu_fetch) begin
              last_fetch_q <= rg;
            end
            if (acc_err) begin
              cpu_err <= 1'b1;
              cpu_done <= 1'b1;
            end else begin
              case (rg)
                RGN_SFR, RGN_EXTENDED_REGISTER_BLOCK: begin
                  if (cpu_we && cpu_bitop == BO_NONE) begin
                    cpu_done <= 1'b1;
                  end else begin
                    st_q <= ST_SFR_RD;
                  end
                end
                RGN_EXTENSION_RAM: begin
                  st_q <= ST_EXTENSION_RAM;
                  cnt_q <= EXTENSION_RAM_CYC - 2'h1;
                  hold_xm_q <= 1'b0;
                end
                default: begin
                  // Everything not claimed on chip leaves through the far side
                  ext_req <= (rg == RGN_EXT);
                  iram_req <= (rg == RGN_IRAM);
                  far_we <= cpu_we;
                  far_byte <= cpu_byte;
                  far_addr <= sel_phys[15:0];
                  far_wdata <= cpu_wdata;
                  case (bank_mode)
                    BK_256K: port4_addr <= {5'h00, sel_phys[17:16]};
                    BK_1M: port4_addr <= {3'h0, sel_phys[19:16]};
                    BK_8M: port4_addr <= sel_phys[22:16];
                    default: port4_addr <= 7'h00;
                  endcase
                  st_q <= ST_FAR;
                end
              endcase
            end
          end
        end
        ST_SFR_RD: begin
          st_q <= ST_IDLE;
          cpu_done <= 1'b1;
          cpu_bit <= |(sr_rdata & bit_mask);
          if (hold_byte_q) begin
            cpu_rdata <= {8'h00, hold_lsb_q ? sr_rdata[15:8] : sr_rdata[7:0]};
          end else begin
            cpu_rdata <= sr_rdata;
          end
        end
        ST_EXTENSION_RAM: begin
          if (cnt_q == 2'h0) begin
            st_q <= ST_IDLE;
            if (hold_xm_q) begin
              xm_ack <= 1'b1;
              xm_rdata <= xr_rdata;
            end else begin
              cpu_done <= 1'b1;
              cpu_rdata <= hold_byte_q ? {8'h00, hold_lsb_q ? xr_rdata[15:8] : xr_rdata[7:0]}
                                       : xr_rdata;
            end
          end else begin
            cnt_q <= cnt_q - 2'h1;
          end
        end
        ST_FAR: begin
          if (far_ack) begin
            st_q <= ST_IDLE;
            cpu_done <= 1'b1;
            cpu_rdata <= far_rdata;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_byte_clears_other: assert property (@(posedge ref_clk) disable iff (!nrst)
    (ce && take && !acc_err && (rg == RGN_SFR || rg == RGN_EXTENDED_REGISTER_BLOCK) && cpu_we && cpu_byte
     && cpu_bitop == BO_NONE)
    |-> (sel_phys[0] ? sr_wdata[7:0] == 8'h00 : sr_wdata[15:8] == 8'h00))
    else $error("byte write left other byte intact");

  a_extension_ram_cycle_len: assert property (@(posedge ref_clk) disable iff (!nrst)
    (ce && take && !acc_err && rg == RGN_EXTENSION_RAM) ##1 ce ##1 ce |=> cpu_done && !cpu_err)
    else $error("extension RAM cycle not two clocks");

  a_extension_ram_no_ext: assert property (@(posedge ref_clk) disable iff (!nrst)
    (ce && take && rg == RGN_EXTENSION_RAM) |=> !ext_req [*2])
    else $error("external cycle on extension RAM hit");

  a_extension_ram_off_ext: assert property (@(posedge ref_clk) disable iff (!nrst)
    (ce && take && !acc_err && !syscfg_q[SYSCFG_XEN_BIT]
     && sel_phys >= EXTENSION_RAM_BASE && sel_phys <= EXTENSION_RAM_END) |=> ext_req)
    else $error("disabled extension range not routed out");

  a_cfg_locked: assert property (@(posedge ref_clk) disable iff (!nrst)
    locked_q |=> $stable(syscfg_q))
    else $error("configuration changed after lock");

  a_csp_only_branch: assert property (@(posedge ref_clk) disable iff (!nrst)
    !(ce && segment_branch) |=> $stable(csp_q))
    else $error("code segment changed without branch");

  a_bit_lower_half: assert property (@(posedge ref_clk) disable iff (!nrst)
    (ce && take && cpu_bitop != BO_NONE && (rg == RGN_SFR || rg == RGN_EXTENDED_REGISTER_BLOCK) && !upper)
    |=> cpu_err && cpu_done)
    else $error("bit operation allowed in lower half");

  a_gpr_any_window: assert property (@(posedge ref_clk) disable iff (!nrst)
    (ce && take && cpu_mode == AM_GPR && !acc_err && ext_window)
    |=> iram_req && far_addr == 16'(cp_q + {11'h000, $past(cpu_addr[3:0]), 1'b0}))
    else $error("general register not reached under window");

  a_xm_ack_time: assert property (@(posedge ref_clk) disable iff (!nrst)
    (ce && xm_take && xm_ok) ##1 ce ##1 ce |=> xm_ack && !cpu_done)
    else $error("external master access not answered in two clocks");

endmodule

// ==== msd_far_mem.sv ====
`timescale 1ns/1ps
module msd_far_mem (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Far access
  input wire logic ext_req,
  input wire logic [15:0] far_addr,
  input wire logic slow,
  output logic far_ack,
  output logic [15:0] far_rdata
);
  logic [2:0] cnt_q;
  logic busy_q;
  // ****************************************
  // External memory answering promptly or slowly
  // ****************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      busy_q <= 1'b0;
      cnt_q <= 3'h0;
      far_ack <= 1'b0;
      far_rdata <= 16'h0000;
    end else begin
      far_ack <= 1'b0;
      // Released data lines keep changing so stale values never match
      far_rdata <= ~far_rdata;
      if (ext_req) begin
        busy_q <= 1'b1;
        cnt_q <= slow ? 3'h5 : 3'h0;
      end else if (busy_q && cnt_q != 3'h0) begin
        cnt_q <= cnt_q - 3'h1;
      end else if (busy_q) begin
        busy_q <= 1'b0;
        far_ack <= 1'b1;
        far_rdata <= ~far_addr;
      end
    end
  end
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import msd_pkg::*;
  typedef struct {logic we; logic byt; msd_bitop_t bop; logic [15:0] a; logic [15:0] wd;
    logic err; msd_region_t rgn; logic [15:0] rd; int lat;} msd_row_t;
  logic ref_clk = 0, nrst = 0, ce = 1, reg_we = 0, reg_re = 0, cpu_req = 0, cpu_we = 0;
  logic cpu_byte = 0, eoi = 0, slow = 0, xm_hold = 0, xm_req = 0, far_ack;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000, cpu_addr = 16'h0000, cpu_wdata = 16'h0000;
  logic [15:0] reg_rdata, cpu_rdata, far_addr, far_rdata, xm_rdata, got;
  logic [3:0] strap = 4'h6;
  logic fetch = 0, ews = 0, segbr = 0, eapin_n = 1, xm_we = 0;
  msd_amode_t mode = AM_LONG;
  logic [3:0] bitpos = 4'h3;
  logic [7:0] segt = 8'h00;
  logic [23:0] xm_addr = 24'h00E000;
  logic [15:0] xm_wdata = 16'h0000;
  msd_bitop_t bop = BO_NONE;
  logic cpu_done, cpu_err, ext_req, xm_ack, xm_err;
  msd_region_t region;
  msd_bus_t bus_mode;
  msd_bank_t bank_mode;
  int num_errors = 0, cmp_count = 0, ext_cnt = 0, lat;
  msd_row_t rows[10] = '{
    '{1, 0, BO_NONE, 16'hFE10, 16'hA55A, 0, RGN_SFR, 16'h0000, 1},
    '{1, 1, BO_NONE, 16'hFE10, 16'h0033, 0, RGN_SFR, 16'h0000, 1},
    '{0, 0, BO_NONE, 16'hFE10, 16'h0000, 0, RGN_SFR, 16'h0033, 2},
    '{1, 0, BO_NONE, 16'hF000, 16'h7E01, 0, RGN_EXTENDED_REGISTER_BLOCK, 16'h0000, 1},
    '{1, 0, BO_NONE, 16'hE000, 16'h1234, 0, RGN_EXTENSION_RAM, 16'h0000, 3},
    '{0, 0, BO_NONE, 16'hE7FE, 16'h0000, 0, RGN_EXTENSION_RAM, 16'h0000, 0},
    '{0, 0, BO_NONE, 16'hE000, 16'h0000, 0, RGN_EXTENSION_RAM, 16'h1234, 3},
    '{0, 0, BO_NONE, 16'hE001, 16'h0000, 1, RGN_EXTENSION_RAM, 16'h0000, 1},
    '{0, 0, BO_SET, 16'hFE10, 16'h0000, 1, RGN_SFR, 16'h0000, 1},
    '{0, 0, BO_TEST, 16'hE000, 16'h0000, 1, RGN_EXTENSION_RAM, 16'h0000, 1}};
  msd_decoder uut (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_byte(cpu_byte), .cpu_fetch(fetch),
    .cpu_seq(1'b0), .cpu_mode(mode), .cpu_bitop(bop), .cpu_bitpos(bitpos),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_done(cpu_done),
    .cpu_err(cpu_err), .cpu_bit(), .region(region), .extended_window_switch(ews),
    .extended_window_switch_count_m1(2'h0), .instr_retire(1'b0), .end_of_init_instruction(eoi),
    .segment_branch(segbr), .seg_target(segt), .external_access_pin_n(eapin_n),
    .port0_strap(strap), .bus_mode(bus_mode), .bank_mode(bank_mode), .ext_req(ext_req),
    .iram_req(), .far_we(), .far_byte(), .far_addr(far_addr), .port4_addr(),
    .far_wdata(), .far_ack(far_ack), .far_rdata(far_rdata), .xm_hold(xm_hold),
    .xm_req(xm_req), .xm_we(xm_we), .xm_be(2'h3), .xm_addr(xm_addr),
    .xm_wdata(xm_wdata), .xm_rdata(xm_rdata), .xm_ack(xm_ack), .xm_err(xm_err));
  msd_far_mem far (.ref_clk(ref_clk), .nrst(nrst), .ext_req(ext_req), .far_addr(far_addr),
    .slow(slow), .far_ack(far_ack), .far_rdata(far_rdata));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) ext_cnt += ext_req;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic reg_io(input logic wr, input logic [2:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_we <= wr;
    reg_re <= !wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_we <= 1'b0;
    reg_re <= 1'b0;
    #1 got = reg_rdata;
  endtask
  task automatic cpu(input msd_row_t r);
    @(posedge ref_clk);
    {cpu_req, cpu_we, cpu_byte, bop, cpu_addr, cpu_wdata} <= {1'b1, r.we, r.byt, r.bop, r.a, r.wd};
    lat = 0;
    do begin
      @(posedge ref_clk);
      #1 lat++;
    end while (!cpu_done && lat < 40);
    cpu_req <= 1'b0;
    check(cpu_err, r.err);
    if (!r.err) check(region, r.rgn);
    if (!r.we && !r.err && (r.lat != 0 || r.rgn == RGN_EXT)) check(cpu_rdata, r.rd);
    if (r.lat != 0) check(lat, r.lat);
  endtask
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    check(bus_mode, BUS_MUX16);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    strap <= 4'h0;
    #1 check({bus_mode, bank_mode}, {BUS_DMX16, BK_256K});
    reg_io(0, RG_SYSCFG, 0);
    check(got, 16'h0000);
    reg_io(1, RG_DPP3, 16'h0003);
    cpu('{0, 0, BO_NONE, 16'hE000, 0, 0, RGN_EXT, 16'h1FFF, 0});
    slow <= 1'b1;
    cpu('{0, 0, BO_NONE, 16'h4000, 0, 0, RGN_EXT, 16'hFFFF, 0});
    reg_io(1, RG_SYSCFG, 16'h0003);
    lat = ext_cnt;
    foreach (rows[i]) cpu(rows[i]);
    check(ext_cnt, 2);
    @(posedge ref_clk);
    xm_hold <= 1'b1;
    xm_req <= 1'b1;
    @(posedge ref_clk);
    xm_req <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 check({xm_ack, xm_err, xm_rdata}, {2'b10, 16'h1234});
    xm_hold <= 1'b0;
    eoi <= 1'b1;
    @(posedge ref_clk);
    eoi <= 1'b0;
    reg_io(1, RG_SYSCFG, 16'h0000);
    reg_io(0, RG_SYSCFG, 0);
    check(got, 16'h0003);
    segt <= 8'h5A;
    segbr <= 1'b1;
    @(posedge ref_clk);
    segbr <= 1'b0;
    reg_io(0, RG_CSP, 0);
    check(got, 16'h005A);
    tally_and_finish();
  end
endmodule
